//--- shared/fcf_regs.svh
// timing constants and fixed widths for the fan commutation and fault logic
`ifndef FCF_REGS_SVH
`define FCF_REGS_SVH
`define FCF_CLK_HZ          200000000
`define FCF_PWM_HZ          30000
`define FCF_PWM_PERIOD      (`FCF_CLK_HZ / `FCF_PWM_HZ)
`define FCF_NONOVL_US       70
`define FCF_NONOVL_CYC      ((`FCF_NONOVL_US * (`FCF_CLK_HZ / 1000000)))
`define FCF_LOCK_MS         500
`define FCF_LOCK_CYC        (`FCF_LOCK_MS * (`FCF_CLK_HZ / 1000))
`define FCF_COOL_MS         8000
`define FCF_COOL_CYC        (`FCF_COOL_MS * (`FCF_CLK_HZ / 1000))
`define FCF_RETRY_MS        500
`define FCF_RETRY_CYC       (`FCF_RETRY_MS * (`FCF_CLK_HZ / 1000))
`define FCF_SPEED_W         8
`define FCF_SPEED_MAX       8'hFF
`define FCF_CNT_W           32
`endif

//--- shared/fcf_pkg.sv
// types shared by the fan commutation and fault logic
package fcf_pkg;
  typedef enum logic [3:0] {
    FCF_RUN    = 4'b0001,
    FCF_LOCKED = 4'b0010,
    FCF_COOL   = 4'b0100,
    FCF_RETRY  = 4'b1000
  } fcf_lock_e;

  typedef struct packed {
    logic high_side_drive_a;
    logic high_side_drive_b;
    logic low_side_drive_a;
    logic low_side_drive_b;
  } fcf_bridge_s;

  typedef struct packed {
    logic overcurrent;
    logic overtemp;
    logic undervoltage;
  } fcf_fault_s;
endpackage

//--- design/fcf_core.sv
// commutation, bottom drive modulation and fault gating for a single phase fan pre-driver
// What this block does
// - chop the active low-side drive with a 30 kHz duty modulated waveform
// - at most one low-side drive is active, chosen by rotor polarity
// - high-side drives never modulated; change only with commutation state
// - 70 us non-overlap with whole bridge off on every commutation change
// - no polarity change for 0.5 s declares locked rotor, low sides off
// - after locked rotor keep low sides off for 8 s cool-down
// - 0.5 s retry after cool-down; resume on polarity change, else repeat while commanded
// - low sides held off during undervoltage; hysteresis done by the comparator
// - low sides off while over-temperature flag shows die too hot
// - over-current immediately turns low-side drives off
// - after over-current re-enable at next modulation period if comparator clear
// - tachometer output toggles on each rotor polarity change
// - target speed is larger of commanded speed and floor speed
// - duty input maps linearly, 0% zero speed, 100% full speed
// - analog command code maps linearly, 1 V zero, 3 V full speed
// - floor setting code maps linearly, 1 V zero, 3 V full speed
`timescale 1ns/1ps
`include "fcf_regs.svh"
module fcf_core
  import fcf_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_rotor_sensor_pol,
  input  wire logic                    i_speed_duty,
  input  wire logic                    i_speed_duty_mode,
  input  wire logic [`FCF_SPEED_W-1:0] i_speed_command_level,
  input  wire logic [`FCF_SPEED_W-1:0] i_floor_speed_level,
  input  wire logic                    i_overcurrent_sense,
  input  wire logic                    i_overtemp,
  input  wire logic                    i_undervoltage,
  input  wire logic                    i_run_cmd,
  output logic                         o_high_side_drive_a,
  output logic                         o_high_side_drive_b,
  output logic                         o_low_side_drive_a,
  output logic                         o_low_side_drive_b,
  output logic                         o_tach_out,
  output logic                         o_tach_oe,
  output logic                         o_locked,
  output logic [`FCF_SPEED_W-1:0]      o_target_speed
);
  localparam logic [`FCF_CNT_W-1:0] PWM_PER  = `FCF_CNT_W'(`FCF_PWM_PERIOD);
  localparam logic [`FCF_CNT_W-1:0] NOVL_CYC = `FCF_CNT_W'(`FCF_NONOVL_CYC);
  localparam logic [`FCF_CNT_W-1:0] LOCK_CYC = `FCF_CNT_W'(`FCF_LOCK_CYC);
  localparam logic [`FCF_CNT_W-1:0] COOL_CYC = `FCF_CNT_W'(`FCF_COOL_CYC);
  localparam logic [`FCF_CNT_W-1:0] RTRY_CYC = `FCF_CNT_W'(`FCF_RETRY_CYC);

  // synchronisers: stage one feeds stage two only
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1 <= 5'h0;
      sync2 <= 5'h0;
    end
    else
    begin
      sync1 <= {i_rotor_sensor_pol, i_speed_duty, i_overcurrent_sense, i_overtemp, i_undervoltage};
      sync2 <= sync1;
    end
  end
  logic       pol_s;
  logic       duty_s;
  fcf_fault_s flt;
  assign pol_s  = sync2[4];
  assign duty_s = sync2[3];
  assign flt    = '{overcurrent: sync2[2], overtemp: sync2[1], undervoltage: sync2[0]};

  // polarity edge and commutation state
  logic                  pol_q;
  logic                  phase;
  logic                  tach;
  logic [`FCF_CNT_W-1:0] novl_cnt;
  logic                  next_pol_q;
  logic                  next_phase;
  logic                  next_tach;
  logic [`FCF_CNT_W-1:0] next_novl_cnt;
  logic                  pol_edge;
  assign pol_edge = pol_s ^ pol_q;
  always_comb
  begin
    next_pol_q    = pol_s;
    next_phase    = phase;
    next_tach     = tach;
    next_novl_cnt = novl_cnt;
    if (pol_edge)
    begin
      next_phase    = pol_s;
      next_tach     = ~tach;
      next_novl_cnt = NOVL_CYC;
    end
    else if (novl_cnt != '0)
      next_novl_cnt = novl_cnt - 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pol_q    <= 1'b0;
      phase    <= 1'b0;
      tach     <= 1'b0;
      novl_cnt <= '0;
    end
    else
    begin
      pol_q    <= next_pol_q;
      phase    <= next_phase;
      tach     <= next_tach;
      novl_cnt <= next_novl_cnt;
    end
  end

  // duty measurement over one modulation period gives the commanded speed
  logic [`FCF_CNT_W-1:0]   pwm_cnt;
  logic [`FCF_CNT_W-1:0]   hi_cnt;
  logic [`FCF_SPEED_W-1:0] duty_speed;
  logic [`FCF_CNT_W-1:0]   next_pwm_cnt;
  logic [`FCF_CNT_W-1:0]   next_hi_cnt;
  logic [`FCF_SPEED_W-1:0] next_duty_speed;
  logic                    period_start;
  logic [`FCF_CNT_W+7:0]   scaled;
  assign period_start = (pwm_cnt == '0);
  always_comb
  begin
    // count this cycle's sample too, so a period that is high throughout reaches full scale
    scaled          = {8'h00, hi_cnt + {31'h0, duty_s}} * 40'(`FCF_SPEED_MAX);
    next_duty_speed = duty_speed;
    next_pwm_cnt    = (pwm_cnt == PWM_PER - 1'b1) ? '0 : pwm_cnt + 1'b1;
    next_hi_cnt     = hi_cnt + {31'h0, duty_s};
    if (pwm_cnt == PWM_PER - 1'b1)
    begin
      next_duty_speed = `FCF_SPEED_W'(scaled / 40'(`FCF_PWM_PERIOD));
      next_hi_cnt     = '0;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pwm_cnt    <= '0;
      hi_cnt     <= '0;
      duty_speed <= '0;
    end
    else
    begin
      pwm_cnt    <= next_pwm_cnt;
      hi_cnt     <= next_hi_cnt;
      duty_speed <= next_duty_speed;
    end
  end

  // level codes are already 0 at 1 V and full scale at 3 V from the front-end converter
  logic [`FCF_SPEED_W-1:0] cmd_speed;
  logic [`FCF_SPEED_W-1:0] target;
  assign cmd_speed = i_speed_duty_mode ? duty_speed : i_speed_command_level;
  assign target    = (cmd_speed > i_floor_speed_level) ? cmd_speed : i_floor_speed_level;

  // locked rotor supervisor
  fcf_lock_e             lk;
  logic [`FCF_CNT_W-1:0] lk_cnt;
  fcf_lock_e             next_lk;
  logic [`FCF_CNT_W-1:0] next_lk_cnt;
  always_comb
  begin
    next_lk     = lk;
    next_lk_cnt = lk_cnt + 1'b1;
    unique case (lk)
      FCF_RUN:
        if (pol_edge)
          next_lk_cnt = '0;
        else if (lk_cnt >= LOCK_CYC - 1'b1)
        begin
          next_lk     = FCF_LOCKED;
          next_lk_cnt = '0;
        end
      FCF_LOCKED:
      begin
        next_lk     = FCF_COOL;
        next_lk_cnt = '0;
      end
      FCF_COOL:
        if (lk_cnt >= COOL_CYC - 1'b1)
        begin
          next_lk     = i_run_cmd ? FCF_RETRY : FCF_COOL;
          next_lk_cnt = i_run_cmd ? '0 : lk_cnt;
        end
      FCF_RETRY:
        if (pol_edge)
        begin
          next_lk     = FCF_RUN;
          next_lk_cnt = '0;
        end
        else if (lk_cnt >= RTRY_CYC - 1'b1)
        begin
          next_lk     = FCF_COOL;
          next_lk_cnt = '0;
        end
      default:
      begin
        next_lk     = FCF_COOL;
        next_lk_cnt = '0;
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lk     <= FCF_RUN;
      lk_cnt <= '0;
    end
    else
    begin
      lk     <= next_lk;
      lk_cnt <= next_lk_cnt;
    end
  end

  // over-current latch: sets at once, clears only at a period start with comparator clear
  logic oc_latch;
  logic next_oc_latch;
  always_comb
  begin
    next_oc_latch = oc_latch;
    if (flt.overcurrent)
      next_oc_latch = 1'b1;
    else if (period_start)
      next_oc_latch = 1'b0;
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      oc_latch <= 1'b0;
    else
      oc_latch <= next_oc_latch;
  end

  // output stage; comparator is also gated directly so the turn-off needs no latch cycle
  logic        lo_en;
  logic        chop;
  logic        novl;
  fcf_bridge_s next_br;
  fcf_bridge_s br;
  assign novl  = pol_edge || (novl_cnt != '0);
  assign lo_en = (lk == FCF_RUN || lk == FCF_RETRY) && !oc_latch && !flt.overcurrent
                 && !flt.overtemp && !flt.undervoltage;
  assign chop  = ({24'h0, target} * PWM_PER) > ({24'h0, 8'h00} | (pwm_cnt * 32'(`FCF_SPEED_MAX)));
  always_comb
  begin
    next_br = '0;
    if (!novl)
    begin
      next_br.high_side_drive_a = phase;
      next_br.high_side_drive_b = !phase;
      next_br.low_side_drive_a  = !phase && lo_en && chop;
      next_br.low_side_drive_b  = phase && lo_en && chop;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      br <= '0;
    else
      br <= next_br;
  end
  logic [`FCF_SPEED_W-1:0] tgt_q;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tgt_q <= '0;
    else
      tgt_q <= target;
  end

  assign o_high_side_drive_a = br.high_side_drive_a;
  assign o_high_side_drive_b = br.high_side_drive_b;
  assign o_low_side_drive_a  = br.low_side_drive_a;
  assign o_low_side_drive_b  = br.low_side_drive_b;
  assign o_tach_out          = 1'b0;
  assign o_tach_oe           = !tach;   // open drain: pulls low while tach state is zero
  assign o_locked            = (lk == FCF_LOCKED || lk == FCF_COOL);
  assign o_target_speed      = tgt_q;

  AST_ONE_LOW: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(o_low_side_drive_a && o_low_side_drive_b)) else $error("both low sides on");
  AST_NOVL: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    pol_edge |=> !o_high_side_drive_a && !o_high_side_drive_b && !o_low_side_drive_a && !o_low_side_drive_b)
    else $error("bridge driven during non-overlap");
  // outputs are registered, so the two sampled outputs follow the state one and two cycles back
  AST_HS_STEADY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ($past(i_reset_n, 2) && $past(novl_cnt, 2) == '0 && $past(novl_cnt) == '0
     && !$past(pol_edge, 2) && !$past(pol_edge) && $past(phase, 2) == $past(phase))
    |-> $stable(o_high_side_drive_a) && $stable(o_high_side_drive_b))
    else $error("high side changed without commutation");
  AST_OC_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    flt.overcurrent |=> !o_low_side_drive_a && !o_low_side_drive_b) else $error("low side on in overcurrent");
  AST_OC_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (oc_latch && !period_start && !flt.overcurrent) |=> oc_latch) else $error("overcurrent released mid period");
  AST_UV_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    flt.undervoltage |=> !o_low_side_drive_a && !o_low_side_drive_b) else $error("low side on in undervoltage");
  AST_OT_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    flt.overtemp |=> !o_low_side_drive_a && !o_low_side_drive_b) else $error("low side on in overtemp");
  AST_TACH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    pol_edge |=> (o_tach_oe != $past(o_tach_oe))) else $error("tach did not toggle");
  AST_LOCK_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (lk == FCF_COOL) |=> !o_low_side_drive_a && !o_low_side_drive_b) else $error("drive during cool-down");
  AST_FLOOR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_target_speed >= $past(i_floor_speed_level)) else $error("target below floor");
  COV_COMMUTE: cover property (@(posedge i_clk) disable iff (!i_reset_n) pol_edge ##1 novl_cnt != '0);
  COV_LOCK: cover property (@(posedge i_clk) disable iff (!i_reset_n) lk == FCF_RUN ##1 lk == FCF_LOCKED);
  COV_RETRY_OK: cover property (@(posedge i_clk) disable iff (!i_reset_n) lk == FCF_RETRY ##1 lk == FCF_RUN);
  COV_OC: cover property (@(posedge i_clk) disable iff (!i_reset_n) oc_latch ##1 !oc_latch);
endmodule

//--- verification/fcf_bridge_model.sv
// behavioural h-bridge that flags a leg shorted through both of its switches
`timescale 1ns/1ps
module fcf_bridge_model
  import fcf_pkg::*;
(
  input  wire logic        i_clk,
  input  wire fcf_bridge_s i_bridge,
  output logic             o_shoot
);
  initial o_shoot = 1'b0;
  // latched so that a single-cycle overlap is not lost between samples
  always @(posedge i_clk)
  begin
    if ((i_bridge.high_side_drive_a && i_bridge.low_side_drive_a) ||
        (i_bridge.high_side_drive_b && i_bridge.low_side_drive_b))
      o_shoot <= 1'b1;
  end
endmodule

//--- verification/fcf_core_test.sv
// self-checking bench for the fan commutation and fault logic
`timescale 1ns/1ps
`include "fcf_regs.svh"
module fcf_core_test;
  import fcf_pkg::*;
  localparam int PER = `FCF_PWM_PERIOD;
  localparam int NOV = `FCF_NONOVL_CYC;
  typedef struct {logic m; logic d; logic [7:0] c; logic [7:0] f; logic [7:0] e; int w;} fcf_row_s;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pol = 1'b0;
  logic        duty = 1'b0;
  logic        mode = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  flr = 8'h00;
  fcf_fault_s  flt = '0;
  fcf_bridge_s br;
  logic        toe;
  logic        lkd;
  logic        shoot;
  logic        tach;
  logic [7:0]  spd;
  logic        tout;
  logic        t0;
  int          failures = 0;
  int          n_checks = 0;
  int          cnt;
  int          seen;
  int          chg;
  fcf_row_s rows [6] = '{
    '{1'b0, 1'b0, 8'h40, 8'h20, 8'h40, 8},
    '{1'b0, 1'b0, 8'h10, 8'h80, 8'h80, 8},
    '{1'b0, 1'b0, 8'hFF, 8'h01, 8'hFF, 8},
    '{1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8},
    '{1'b1, 1'b1, 8'h00, 8'h00, 8'hFF, 2*PER+20},
    '{1'b1, 1'b0, 8'h00, 8'h30, 8'h30, 2*PER+20}
  };

  always #2.5 clk = ~clk;
  // open-drain tach line with an external pull-up
  assign tach = toe ? 1'b0 : 1'b1;

  fcf_core dut (
    .i_clk                 (clk),
    .i_reset_n             (rst_n),
    .i_rotor_sensor_pol    (pol),
    .i_speed_duty          (duty),
    .i_speed_duty_mode     (mode),
    .i_speed_command_level (cmd),
    .i_floor_speed_level   (flr),
    .i_overcurrent_sense   (flt.overcurrent),
    .i_overtemp            (flt.overtemp),
    .i_undervoltage        (flt.undervoltage),
    .i_run_cmd             (1'b1),
    .o_high_side_drive_a   (br.high_side_drive_a),
    .o_high_side_drive_b   (br.high_side_drive_b),
    .o_low_side_drive_a    (br.low_side_drive_a),
    .o_low_side_drive_b    (br.low_side_drive_b),
    .o_tach_out            (tout),
    .o_tach_oe             (toe),
    .o_locked              (lkd),
    .o_target_speed        (spd)
  );

  fcf_bridge_model bridge (
    .i_clk    (clk),
    .i_bridge (br),
    .o_shoot  (shoot)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // counts are compared at full width so that a large count cannot wrap to the expected value
  task automatic chk_n(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // counts cycles in which any bridge switch is on
  task automatic count_on(input int n);
    repeat (n)
    begin
      @(negedge clk);
      if (br !== 4'h0)
        cnt++;
    end
  endtask

  task automatic wait_low(input int bound);
    int i;
    for (i = 0; i < bound && (br.low_side_drive_a | br.low_side_drive_b) !== 1'b1; i++)
      @(negedge clk);
    if ((br.low_side_drive_a | br.low_side_drive_b) !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: low side never drove", $time);
      print_verdict();
    end
  endtask

  initial
  begin
    cyc(3);
    chk({br, toe, lkd}, 8'h02, "reset drives");
    chk(spd, 8'h00, "reset speed");
    chk(tout, 1'b0, "tach data");
    $display("test reset done");
    cyc(2);
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      mode = rows[k].m;
      duty = rows[k].d;
      cmd = rows[k].c;
      flr = rows[k].f;
      cyc(rows[k].w);
      chk(spd, rows[k].e, "target speed");
    end
    $display("test speed table done");
    mode = 1'b0;
    cmd = 8'h80;
    flr = 8'h00;
    cyc(10);
    // a second edge inside the gap must restart the whole off interval
    t0 = tach;
    cnt = 0;
    pol = 1'b1;
    cyc(3);
    chk(tach, !t0, "tach toggle");
    count_on(5000);
    pol = 1'b0;
    cyc(3);
    chk(tach, t0, "tach toggle back");
    count_on(NOV - 4);
    chk_n(cnt, 0, "bridge on in gap");
    cyc(10);
    chk({br.high_side_drive_a, br.high_side_drive_b}, 8'h01, "high side phase");
    cnt = 0;
    seen = 0;
    chg = 0;
    t0 = br.low_side_drive_a;
    repeat (2 * PER)
    begin
      @(negedge clk);
      if (br.low_side_drive_a === 1'b1 && t0 === 1'b0)
        cnt++;
      t0 = br.low_side_drive_a;
      if (br.low_side_drive_b !== 1'b0)
        seen++;
      if (br.high_side_drive_a !== 1'b0 || br.high_side_drive_b !== 1'b1)
        chg++;
    end
    chk_n(cnt, 2, "chop pulses");
    chk_n(seen, 0, "idle low side");
    chk_n(chg, 0, "high side moved");
    $display("test commutation done");
    for (int f = 0; f < 3; f++)
    begin
      wait_low(2 * PER);
      flt = fcf_fault_s'(3'b100 >> f);
      cyc(4);
      cnt = 0;
      repeat (1000)
      begin
        @(negedge clk);
        if ((br.low_side_drive_a | br.low_side_drive_b) !== 1'b0)
          cnt++;
      end
      chk_n(cnt, 0, "low side during fault");
      chk(br.high_side_drive_b, 1'b1, "high side during fault");
      flt = '0;
      wait_low(2 * PER);
      // released at a period start, the half-duty chop stays on well past 3000 cycles
      if (f == 0)
      begin
        seen = 0;
        repeat (3000)
        begin
          @(negedge clk);
          if (br.low_side_drive_a === 1'b1)
            seen++;
        end
        chk_n(seen, 3000, "overcurrent released mid period");
      end
    end
    chk(lkd, 1'b0, "locked flag");
    chk(shoot, 1'b0, "leg shorted");
    $display("test faults done");
    print_verdict();
  end
endmodule
